// ---- hw/lpc_regs.sv ----
// indicator and transceiver general control registers with APB access
//
// Behaviour
// - indicator_control bits 15:11 read zero and ignore writes.
// - blink field 10:9 sets 50/100/200/500 ms on/off; resets to 10.
// - bit 8: speed polarity; strap loads, writes override.
// - bit 7: link polarity; strap loads, writes override.
// - bit 6: activity polarity; strap loads, writes override.
// - bit 5 forces speed indicator to bit 2, else normal speed status.
// - bit 4 forces link indicator to bit 1, else normal link status.
// - bit 3 forces activity indicator to bit 0, else normal activity.
// - general bit 15 enables auto crossover; resets 1, strap loads it.
// - general bit 14 swaps transmit and receive twisted pairs.
// - read-only bit 13 gives resolved pause receive, full duplex only.
// - read-only bit 12 gives resolved pause transmit, full duplex only.
//
// Added by the designer: the APB slave port.
module lpc_regs #(
    parameter int unsigned BLINK_CYC_0 = lpc_pkg::BLINK_CYC_0,
    parameter int unsigned BLINK_CYC_1 = lpc_pkg::BLINK_CYC_1,
    parameter int unsigned BLINK_CYC_2 = lpc_pkg::BLINK_CYC_2,
    parameter int unsigned BLINK_CYC_3 = lpc_pkg::BLINK_CYC_3
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        strap_speed_pol,
    input  wire logic        strap_link_pol,
    input  wire logic        strap_act_pol,
    input  wire logic        strap_mdix_en,
    input  wire logic        speed_100,
    input  wire logic        link_up,
    input  wire logic        activity,
    input  wire logic        hcd_full_duplex,
    input  wire logic [1:0]  local_advert_pause,
    input  wire logic [1:0]  partner_ability_pause,
    input  wire logic        auto_mdix_swap,
    output logic             speed_indicator_pin,
    output logic             link_indicator_pin,
    output logic             activity_indicator_pin,
    output logic             auto_mdix_en,
    output logic             pair_swap,
    output logic             pause_rx_en,
    output logic             pause_tx_en
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic [10:0] ind_r;
    logic [1:0]  gen_r;
    logic [3:0]  strap_s1_r;
    logic [3:0]  strap_s2_r;
    logic [1:0]  strap_cnt_r;
    logic        strap_done_r;
    logic        ind_wr_seen_r;
    logic        gen_wr_seen_r;
    logic [23:0] blink_cnt_r;
    logic        blink_r;
    logic        pause_rx_r;
    logic        pause_tx_r;
    logic [31:0] prdata_r;
    logic        pslverr_r;
    logic        spd_pin_r;
    logic        lnk_pin_r;
    logic        act_pin_r;

    // ------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------
    wire         setup_ph   = psel & ~penable;
    wire         access_ph  = psel & penable;
    wire         hit_ind    = (paddr == lpc_pkg::IND_CTL_ADDR);
    wire         hit_gen    = (paddr == lpc_pkg::GEN_CTL_ADDR);
    wire         hit_any    = hit_ind | hit_gen;
    wire         wr_ind     = access_ph & pwrite & hit_ind;
    wire         wr_gen     = access_ph & pwrite & hit_gen;
    wire         strap_load = (strap_cnt_r == lpc_pkg::STRAP_WAIT)
                              & ~strap_done_r;

    // reserved bits are never stored, so they read back as zero
    wire  [15:0] ind_rd     = {5'h00, ind_r};
    wire  [15:0] gen_rd     = {gen_r, pause_rx_r, pause_tx_r, 12'h000};
    wire  [31:0] rd_mux     = hit_ind ? {16'h0000, ind_rd} :
                              hit_gen ? {16'h0000, gen_rd} : 32'h00000000;

    assign pready  = 1'b1;
    assign prdata  = prdata_r;
    assign pslverr = pslverr_r;

    // ------------------------------------------------------------------
    // read data and error are settled in the setup cycle
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r  <= 32'h00000000;
            pslverr_r <= 1'b0;
        end else if (setup_ph) begin
            prdata_r  <= pwrite ? 32'h00000000 : rd_mux;
            pslverr_r <= ~hit_any;
        end
    end

    // ------------------------------------------------------------------
    // strap capture
    // ------------------------------------------------------------------
    // straps are pins: synchronise, then sample once after the pipe fills
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strap_s1_r   <= 4'h0;
            strap_s2_r   <= 4'h0;
            strap_cnt_r  <= 2'h0;
            strap_done_r <= 1'b0;
        end else begin
            strap_s1_r   <= {strap_mdix_en, strap_speed_pol,
                             strap_link_pol, strap_act_pol};
            strap_s2_r   <= strap_s1_r;
            if (strap_cnt_r != lpc_pkg::STRAP_WAIT) begin
                strap_cnt_r <= strap_cnt_r + 2'h1;
            end
            if (strap_load) begin
                strap_done_r <= 1'b1;
            end
        end
    end

    // a software write before the strap sample keeps precedence
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ind_wr_seen_r <= 1'b0;
            gen_wr_seen_r <= 1'b0;
        end else begin
            if (wr_ind) begin
                ind_wr_seen_r <= 1'b1;
            end
            if (wr_gen) begin
                gen_wr_seen_r <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // indicator_control
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ind_r <= lpc_pkg::IND_CTL_RST;
        end else if (wr_ind) begin
            ind_r <= pwdata[10:0];
        end else if (strap_load && !ind_wr_seen_r) begin
            ind_r[lpc_pkg::IND_SPD_POL] <= strap_s2_r[2];
            ind_r[lpc_pkg::IND_LNK_POL] <= strap_s2_r[1];
            ind_r[lpc_pkg::IND_ACT_POL] <= strap_s2_r[0];
        end
    end

    // ------------------------------------------------------------------
    // transceiver_general_control writable bits
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gen_r <= lpc_pkg::GEN_CTL_RST;
        end else if (wr_gen) begin
            gen_r <= pwdata[lpc_pkg::GEN_MDIX_EN:lpc_pkg::GEN_MDIX_FRC];
        end else if (strap_load && !gen_wr_seen_r) begin
            gen_r[1] <= strap_s2_r[3];
        end
    end

    assign auto_mdix_en = gen_r[1];
    // forced crossover wins over whatever auto-crossover decided
    assign pair_swap    = gen_r[0] | (gen_r[1] & auto_mdix_swap);

    // ------------------------------------------------------------------
    // pause resolution
    // ------------------------------------------------------------------
    wire lp  = local_advert_pause[lpc_pkg::ADV_PAUSE];
    wire la  = local_advert_pause[lpc_pkg::ADV_ASM_DIR];
    wire pp  = partner_ability_pause[lpc_pkg::ADV_PAUSE];
    wire pa  = partner_ability_pause[lpc_pkg::ADV_ASM_DIR];
    wire sym = lp & pp;
    wire rx_res = hcd_full_duplex & (sym | (lp & la & ~pp & pa));
    wire tx_res = hcd_full_duplex & (sym | (~lp & la & pp & pa));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pause_rx_r <= 1'b0;
            pause_tx_r <= 1'b0;
        end else begin
            pause_rx_r <= rx_res;
            pause_tx_r <= tx_res;
        end
    end

    assign pause_rx_en = pause_rx_r;
    assign pause_tx_en = pause_tx_r;

    // ------------------------------------------------------------------
    // blink timer
    // ------------------------------------------------------------------
    wire  [1:0]  blink_sel = ind_r[lpc_pkg::IND_BLINK_LSB +: 2];
    wire  [23:0] blink_len =
        (blink_sel == 2'h0) ? 24'(BLINK_CYC_0) :
        (blink_sel == 2'h1) ? 24'(BLINK_CYC_1) :
        (blink_sel == 2'h2) ? 24'(BLINK_CYC_2) : 24'(BLINK_CYC_3);
    // a rate change takes effect at the next phase boundary
    wire         blink_end = (blink_cnt_r == 24'h000000);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            blink_cnt_r <= 24'h000000;
            blink_r     <= 1'b0;
        end else if (blink_end) begin
            blink_cnt_r <= blink_len - 24'h000001;
            blink_r     <= ~blink_r;
        end else begin
            blink_cnt_r <= blink_cnt_r - 24'h000001;
        end
    end

    // ------------------------------------------------------------------
    // indicator pins
    // ------------------------------------------------------------------
    wire spd_on = ind_r[lpc_pkg::IND_SPD_DRV] ?
                  ind_r[lpc_pkg::IND_SPD_VAL] : speed_100;
    wire lnk_on = ind_r[lpc_pkg::IND_LNK_DRV] ?
                  ind_r[lpc_pkg::IND_LNK_VAL] : link_up;
    // activity blinks only while traffic lasts; a burst that falls in an off phase is not shown
    wire act_on = ind_r[lpc_pkg::IND_ACT_DRV] ?
                  ind_r[lpc_pkg::IND_ACT_VAL] :
                  (activity & blink_r);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            spd_pin_r <= 1'b1;
            lnk_pin_r <= 1'b1;
            act_pin_r <= 1'b1;
        end else begin
            spd_pin_r <= ~(spd_on ^ ind_r[lpc_pkg::IND_SPD_POL]);
            lnk_pin_r <= ~(lnk_on ^ ind_r[lpc_pkg::IND_LNK_POL]);
            act_pin_r <= ~(act_on ^ ind_r[lpc_pkg::IND_ACT_POL]);
        end
    end

    assign speed_indicator_pin    = spd_pin_r;
    assign link_indicator_pin     = lnk_pin_r;
    assign activity_indicator_pin = act_pin_r;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_ind_read;
        setup_ph && !pwrite && hit_ind;
    endsequence

    sequence s_ind_write;
        wr_ind;
    endsequence

    AST_RSVD_ZERO: assert property (
        s_ind_read |=> prdata[15:11] == 5'h00)
        else $error("reserved indicator bits read nonzero");

    AST_BLINK_RELOAD: assert property (
        blink_end && blink_sel == 2'h3 |=>
        blink_cnt_r == 24'(BLINK_CYC_3) - 24'h000001)
        else $error("blink timer reload wrong for slowest rate");

    AST_POL_WRITE: assert property (
        s_ind_write |=> ind_r[8:6] == $past(pwdata[8:6]) ##1
        spd_pin_r == ~($past(spd_on) ^ $past(ind_r[8])))
        else $error("polarity write not applied to speed pin");

    AST_LINK_POL_STRAP: assert property (
        strap_load && !ind_wr_seen_r && !wr_ind |=>
        ind_r[lpc_pkg::IND_LNK_POL] == $past(strap_s2_r[1]))
        else $error("link polarity not taken from strap");

    AST_ACT_POL_STRAP: assert property (
        strap_load && !ind_wr_seen_r && !wr_ind |=>
        ind_r[lpc_pkg::IND_ACT_POL] == $past(strap_s2_r[0]))
        else $error("activity polarity not taken from strap");

    AST_SPEED_FORCE: assert property (
        ind_r[lpc_pkg::IND_SPD_DRV] |=> speed_indicator_pin ==
        ~($past(ind_r[lpc_pkg::IND_SPD_VAL]) ^ $past(ind_r[8])))
        else $error("speed pin ignores forced value");

    AST_LINK_FORCE: assert property (
        ind_r[lpc_pkg::IND_LNK_DRV] |=> link_indicator_pin ==
        ~($past(ind_r[lpc_pkg::IND_LNK_VAL]) ^ $past(ind_r[7])))
        else $error("link pin ignores forced value");

    AST_ACT_FORCE: assert property (
        ind_r[lpc_pkg::IND_ACT_DRV] |=> activity_indicator_pin ==
        ~($past(ind_r[lpc_pkg::IND_ACT_VAL]) ^ $past(ind_r[6])))
        else $error("activity pin ignores forced value");

    AST_MDIX_EN: assert property (
        wr_gen |=> auto_mdix_en == $past(pwdata[lpc_pkg::GEN_MDIX_EN]))
        else $error("crossover enable not written");

    AST_SWAP: assert property (
        gen_r[0] |-> pair_swap)
        else $error("forced crossover did not swap pairs");

    AST_PAUSE_RX: assert property (
        !hcd_full_duplex |=> !pause_rx_en)
        else $error("pause receive set without full duplex");

    AST_PAUSE_TX: assert property (
        hcd_full_duplex && !lp && la && pp && pa |=>
        pause_tx_en && !pause_rx_en)
        else $error("asymmetric pause transmit resolution wrong");

    AST_LINK_NORMAL: assert property (
        !ind_r[lpc_pkg::IND_LNK_DRV] && ind_r[7] && link_up |=>
        link_indicator_pin)
        else $error("active high link pin not high on link");

    AST_SWAP_AUTO_OFF: assert property (
        !auto_mdix_en |-> pair_swap == gen_r[0])
        else $error("pair swap followed crossover request while disabled");

    AST_PAUSE_RX_ASYM: assert property (
        hcd_full_duplex && lp && la && !pp && pa |=>
        pause_rx_en && !pause_tx_en)
        else $error("asymmetric pause receive resolution wrong");

    AST_PAUSE_READ: assert property (
        setup_ph && !pwrite && hit_gen |=>
        prdata[13:12] == {$past(pause_rx_en), $past(pause_tx_en)})
        else $error("pause status bits read back wrong");

    AST_SPEED_NORMAL: assert property (
        !ind_r[lpc_pkg::IND_SPD_DRV] && !ind_r[8] && speed_100 |=>
        !speed_indicator_pin)
        else $error("active low speed pin not low at full speed");

endmodule

// ---- hw/lpc_pkg.sv ----
// constants shared by the indicator and transceiver control register bank
package lpc_pkg;

    // ------------------------------------------------------------------
    // register map (register index, byte address is four times it)
    // ------------------------------------------------------------------
    localparam logic [5:0]  IND_CTL_IDX   = 6'h18;
    localparam logic [5:0]  GEN_CTL_IDX   = 6'h19;
    localparam logic [7:0]  IND_CTL_ADDR  = {IND_CTL_IDX, 2'b00};
    localparam logic [7:0]  GEN_CTL_ADDR  = {GEN_CTL_IDX, 2'b00};

    // ------------------------------------------------------------------
    // indicator_control fields
    // ------------------------------------------------------------------
    localparam int          IND_RSVD_LSB  = 11;
    localparam int          IND_BLINK_LSB = 9;
    localparam int          IND_SPD_POL   = 8;
    localparam int          IND_LNK_POL   = 7;
    localparam int          IND_ACT_POL   = 6;
    localparam int          IND_SPD_DRV   = 5;
    localparam int          IND_LNK_DRV   = 4;
    localparam int          IND_ACT_DRV   = 3;
    localparam int          IND_SPD_VAL   = 2;
    localparam int          IND_LNK_VAL   = 1;
    localparam int          IND_ACT_VAL   = 0;
    localparam logic [10:0] IND_CTL_RST   = 11'h400;

    // ------------------------------------------------------------------
    // transceiver_general_control fields
    // ------------------------------------------------------------------
    localparam int          GEN_MDIX_EN   = 15;
    localparam int          GEN_MDIX_FRC  = 14;
    localparam int          GEN_PAUSE_RX  = 13;
    localparam int          GEN_PAUSE_TX  = 12;
    localparam logic [1:0]  GEN_CTL_RST   = 2'h2;

    // pause advertisement bits within the 11:10 pair
    localparam int          ADV_PAUSE     = 0;
    localparam int          ADV_ASM_DIR   = 1;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_HZ        = 25_000_000;
    localparam int unsigned BLINK_MS_0    = 50;
    localparam int unsigned BLINK_MS_1    = 100;
    localparam int unsigned BLINK_MS_2    = 200;
    localparam int unsigned BLINK_MS_3    = 500;
    localparam int unsigned BLINK_CYC_0   = CLK_HZ / 1000 * BLINK_MS_0;
    localparam int unsigned BLINK_CYC_1   = CLK_HZ / 1000 * BLINK_MS_1;
    localparam int unsigned BLINK_CYC_2   = CLK_HZ / 1000 * BLINK_MS_2;
    localparam int unsigned BLINK_CYC_3   = CLK_HZ / 1000 * BLINK_MS_3;
    localparam logic [1:0]  STRAP_WAIT    = 2'h2;

endpackage

// ---- verif/lpc_led_model.sv ----
// indicator lamps hanging on the three indicator pins
module lpc_led_model (
    input  wire logic [2:0] pins,
    input  wire logic [2:0] pols,
    output logic [2:0]      lit
);
    timeunit 1ns;
    timeprecision 1ps;

    // a lamp glows when its pin sits at the active level set by polarity
    assign lit = ~(pins ^ pols);
endmodule

// ---- verif/tb_lpc_regs.sv ----
// self-checking bench for the indicator and transceiver control bank
module tb_lpc_regs;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------------
    // signals
    // ------------------------------------------------------------------
    localparam logic [7:0]  IND = lpc_pkg::IND_CTL_ADDR;
    localparam logic [7:0]  GEN = lpc_pkg::GEN_CTL_ADDR;
    localparam int unsigned CYC [4] = '{4, 8, 16, 40};
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, q;
    logic        strap_speed_pol, strap_link_pol, strap_act_pol;
    logic        strap_mdix_en, speed_100, link_up, activity;
    logic        hcd_full_duplex, auto_mdix_swap, e, rx, tx;
    logic [1:0]  local_advert_pause, partner_ability_pause;
    logic        speed_indicator_pin, link_indicator_pin;
    logic        activity_indicator_pin, auto_mdix_en, pair_swap;
    logic        pause_rx_en, pause_tx_en;
    logic [2:0]  pol_sh, lit, val, pin3;
    int          err_count, n_tests, c;

    lpc_regs #(
        .BLINK_CYC_0(CYC[0]), .BLINK_CYC_1(CYC[1]),
        .BLINK_CYC_2(CYC[2]), .BLINK_CYC_3(CYC[3])
    ) dut (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .strap_speed_pol, .strap_link_pol,
        .strap_act_pol, .strap_mdix_en, .speed_100, .link_up, .activity,
        .hcd_full_duplex, .local_advert_pause, .partner_ability_pause,
        .auto_mdix_swap, .speed_indicator_pin, .link_indicator_pin,
        .activity_indicator_pin, .auto_mdix_en, .pair_swap,
        .pause_rx_en, .pause_tx_en
    );

    assign pin3 = {speed_indicator_pin, link_indicator_pin,
                   activity_indicator_pin};

    lpc_led_model leds (
        .pins(pin3),
        .pols(pol_sh),
        .lit (lit)
    );

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    // ------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------
    task automatic close_out;
        if (err_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t word got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_bits(input logic [2:0] got, input logic [2:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t bits got %b exp %b", $time, got, exp);
        end
    endtask

    // one full transfer; the leading edge keeps psel from being set twice
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge pclk);
        #1;
    endtask

    task automatic wait_tog(output int cnt);
        logic p;
        p   = activity_indicator_pin;
        cnt = 0;
        do begin
            @(posedge pclk);
            #1;
            cnt++;
        end while (activity_indicator_pin === p && cnt < 200);
    endtask

    // ------------------------------------------------------------------
    // tests
    // ------------------------------------------------------------------
    initial begin
        {psel, penable, pwrite, presetn} = 4'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        {strap_speed_pol, strap_link_pol, strap_act_pol} = 3'b101;
        {strap_mdix_en, speed_100, link_up, activity} = 4'h0;
        {hcd_full_duplex, auto_mdix_swap} = 2'b00;
        local_advert_pause = 2'h0;
        partner_ability_pause = 2'h0;
        pol_sh = 3'b000;
        err_count = 0;
        n_tests = 0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        tick(5);
        apb(1'b0, IND, 32'h0);
        chk(q, 32'h0000_0540);
        chk_bits(pin3, 3'b010);
        apb(1'b0, GEN, 32'h0);
        chk(q, 32'h0000_0000);
        apb(1'b1, IND, 32'hFFFF_FFFF);
        apb(1'b0, IND, 32'h0);
        chk(q, 32'h0000_07FF);
        for (int i = 0; i < 8; i++) begin
            pol_sh = i[2:0];
            val = {i[0], i[2], i[1]};
            apb(1'b1, IND, {21'h0, 2'b10, pol_sh, 3'b111, val});
            tick(2);
            chk_bits(lit, val);
        end
        for (int i = 0; i < 4; i++) begin
            pol_sh = {3{i[1]}};
            @(posedge pclk);
            speed_100 <= i[0];
            link_up <= ~i[0];
            apb(1'b1, IND, {21'h0, 2'b10, pol_sh, 6'h00});
            tick(2);
            chk_bits(lit, {i[0], ~i[0], 1'b0});
        end
        @(posedge pclk);
        activity <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, IND, {21'h0, i[1:0], 3'b111, 6'h00});
            wait_tog(c);
            wait_tog(c);
            wait_tog(c);
            chk(c, CYC[i]);
        end
        apb(1'b1, GEN, 32'h0000_FFFF);
        apb(1'b0, GEN, 32'h0);
        chk(q, 32'h0000_C000);
        chk_bits({auto_mdix_en, pair_swap, 1'b0}, 3'b110);
        apb(1'b1, GEN, 32'h0000_8000);
        auto_mdix_swap <= 1'b1;
        tick(1);
        chk_bits({auto_mdix_en, pair_swap, 1'b0}, 3'b110);
        @(posedge pclk);
        auto_mdix_swap <= 1'b0;
        tick(1);
        chk_bits({auto_mdix_en, pair_swap, 1'b0}, 3'b100);
        apb(1'b1, GEN, 32'h0);
        auto_mdix_swap <= 1'b1;
        tick(1);
        chk_bits({auto_mdix_en, pair_swap, 1'b0}, 3'b000);
        // index bits: fd, local asym, local pause, far asym, far pause
        for (int i = 0; i < 32; i++) begin
            @(posedge pclk);
            {hcd_full_duplex, local_advert_pause,
             partner_ability_pause} <= i[4:0];
            tick(2);
            rx = i[4] & (i[2] & i[0] | i[2] & i[3] & ~i[0] & i[1]);
            tx = i[4] & (i[2] & i[0] | ~i[2] & i[3] & i[0] & i[1]);
            apb(1'b0, GEN, 32'h0);
            chk(q, {18'h0, rx, tx, 12'h000});
            chk({pause_rx_en, pause_tx_en}, {rx, tx});
        end
        apb(1'b1, 8'h68, 32'h0000_FFFF);
        chk_bits({e, 2'b00}, 3'b100);
        apb(1'b0, 8'h68, 32'h0);
        chk(q, 32'h0);
        apb(1'b0, IND, 32'h0);
        chk(q, 32'h0000_07C0);
        chk_bits({e, 2'b00}, 3'b000);
        // a write right after release must win over the strap load
        presetn <= 1'b0;
        tick(1);
        chk_bits(pin3, 3'b111);
        @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b1, IND, 32'h0);
        tick(5);
        apb(1'b0, IND, 32'h0);
        chk(q, 32'h0);
        close_out();
    end

    initial begin
        repeat (20000) @(posedge pclk);
        err_count++;
        close_out();
    end
endmodule
